// File: rcpa_top.sv
// Radio calibration control, power-on timeout and Amplifier_power_index table config block
// Behaviour
// - Auto-calibration select 00 means the synthesizer calibrates only on the manual calibrate strobe.
// - Select 01 starts a calibration on every move from idle into transmit or synth-on transmit-ready.
// - Select 10 starts a calibration every time the radio drops from transmit back to idle.
// - Select 11 counts transmit-to-idle moves and calibrates only on every fourth one.
// - Once the crystal is stable a six-bit ripple counter must expire the set number of times before ready goes low.
// - Power-on timeout select 00, 01, 10, 11 asks for 1, 16, 64 and 256 expiries.
// - The timeout select and the power table entries survive sleep while the other settings fall back to reset.
// - The 3-bit amplifier power index picks one of eight power table entries for transmission.
// - In amplitude keying a one uses the programmed index and a zero uses entry zero.
// - Entries from zero up to the index are stepped through for shaping and for ramps at start and end.
// - A charge-pump calibration enable of zero skips the charge-pump stage of calibration.
// - The 4-bit charge-pump result is written by calibration and may be read and overridden by the host.
// - Calibration results written back by the host become the synthesizer settings in use.
// - A 2-bit field sets the transmit LO buffer current and resets to 1.
`timescale 1ns/1ps
module rcpa_top import rcpa_pkg::*; (
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire logic I_SPI_CS_N,
  input wire logic I_SPI_SCLK,
  input wire logic I_SPI_SI,
  input rcpa_radio_t I_RADIO_STATE,
  input wire logic I_XOSC_STABLE,
  input wire logic I_ASK_MODE,
  input wire logic I_TX_BIT,
  input wire logic [3:0] I_CP_CAL_CODE,
  output logic O_SPI_SO,
  output logic O_CHIP_READY_N,
  output logic O_CAL_BUSY,
  output logic O_CAL_CP_STAGE,
  output logic [3:0] O_CP_CURRENT_CODE,
  output logic [1:0] O_CP_CAL_CONFIG,
  output logic [1:0] O_TX_LO_BUF_CURRENT,
  output logic [7:0] O_PA_SETTING
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  rcpa_req_t req;
  rcpa_cfg_t cfg_q, cfg_d;
  rcpa_radio_t prev_q, prev_d;
  rcpa_cal_t cal_q, cal_d;
  logic [7:0] rd_data;
  logic [7:0] ptab_q [8];
  logic [7:0] ptab_d [8];
  logic [2:0] ptr_q, ptr_d;
  logic [2:0] ramp_idx;
  logic [7:0] pa_q, pa_d;
  logic [9:0] tmr_q, tmr_d;
  logic [1:0] four_q, four_d;
  logic busy_q, busy_d, cpst_q, cpst_d;
  logic [5:0] rip_q, rip_d;
  logic [8:0] exp_q, exp_d, po_target;
  logic rdy_n_q, rdy_n_d;
  logic man_cal, idle_to_tx, tx_to_idle, auto_req, cal_req, cp_done;
  logic radio_sleep, tab_acc;

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  rcpa_spi u_spi (
    .i_clk(I_SYS_CLK),
    .i_rst_n(I_RST_N),
    .i_cs_n(I_SPI_CS_N),
    .i_sclk(I_SPI_SCLK),
    .i_si(I_SPI_SI),
    .i_rdy_n(rdy_n_q),
    .i_rd_data(rd_data),
    .o_req(req),
    .o_so(O_SPI_SO)
  );

  always_comb begin
    rd_data = 8'h00;
    case (req.addr)
      A_RCCAL: begin
        rd_data[AUTOCAL_LSB +: 2] = cfg_q.autocal;
        rd_data[PO_LSB +: 2] = cfg_q.po;
      end
      A_FETX: begin
        rd_data[LOBUF_LSB +: 2] = cfg_q.lobuf;
        rd_data[PAIDX_LSB +: 3] = cfg_q.pa_idx;
      end
      A_CPCAL: begin
        rd_data[CPCFG_LSB +: 2] = cfg_q.cp_cfg;
        rd_data[CPEN_LSB +: 2] = cfg_q.cp_en;
        rd_data[CPRES_LSB +: 4] = cfg_q.cp_res;
      end
      A_PTAB: rd_data = ptab_q[ptr_q];
      default: rd_data = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Configuration fields
  // ----------------------------------------
  always_comb begin
    radio_sleep = (I_RADIO_STATE == RS_SLEEP);
    cfg_d = cfg_q;
    if (radio_sleep) begin
      // Of the config fields only the timeout select is kept powered, so wake-up stays short
      cfg_d = CFG_RST;
      cfg_d.po = cfg_q.po;
    end
    if (req.wr) begin
      case (req.addr)
        A_RCCAL: begin
          cfg_d.autocal = req.wdata[AUTOCAL_LSB +: 2];
          cfg_d.po = req.wdata[PO_LSB +: 2];
        end
        A_FETX: begin
          cfg_d.lobuf = req.wdata[LOBUF_LSB +: 2];
          cfg_d.pa_idx = req.wdata[PAIDX_LSB +: 3];
        end
        A_CPCAL: begin
          cfg_d.cp_cfg = req.wdata[CPCFG_LSB +: 2];
          cfg_d.cp_en = req.wdata[CPEN_LSB +: 2];
          cfg_d.cp_res = req.wdata[CPRES_LSB +: 4];
        end
        default: cfg_d = cfg_d;
      endcase
    end
    // Calibration result beats a host override in the same cycle
    if (cp_done) begin
      cfg_d.cp_res = I_CP_CAL_CODE;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cfg_q <= CFG_RST;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // ----------------------------------------
  // Power table
  // ----------------------------------------
  always_comb begin
    tab_acc = (req.wr || req.rd) && req.addr == A_PTAB;
    ptab_d = ptab_q;
    ptr_d = ptr_q;
    if (I_SPI_CS_N) begin
      ptr_d = 3'h0;
    end else if (tab_acc) begin
      ptr_d = ptr_q + 3'h1;
      if (req.wr) begin
        ptab_d[ptr_q] = req.wdata;
      end
    end
    pa_d = ptab_q[ramp_idx];
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      for (int i = 0; i < 8; i++) begin
        ptab_q[i] <= PTAB_RST;
      end
      ptr_q <= 3'h0;
      pa_q <= PTAB_RST;
    end else begin
      ptab_q <= ptab_d;
      ptr_q <= ptr_d;
      pa_q <= pa_d;
    end
  end

  rcpa_ramp #(
    .IDX_W(3),
    .STEP(RAMP_STEP_CYC)
  ) u_ramp (
    .i_clk(I_SYS_CLK),
    .i_rst_n(I_RST_N),
    .i_tx_on(I_RADIO_STATE == RS_TX),
    .i_ask(I_ASK_MODE),
    .i_bit(I_TX_BIT),
    .i_top(cfg_q.pa_idx),
    .o_idx(ramp_idx)
  );

  // ----------------------------------------
  // Synthesizer calibration sequencer
  // ----------------------------------------
  always_comb begin
    prev_d = I_RADIO_STATE;
    man_cal = req.cmd && req.addr == A_MANCAL;
    idle_to_tx = prev_q == RS_IDLE && (I_RADIO_STATE == RS_TX || I_RADIO_STATE == RS_SYNTH_ON);
    tx_to_idle = prev_q == RS_TX && I_RADIO_STATE == RS_IDLE;
    four_d = four_q;
    if (tx_to_idle && cfg_q.autocal == AC_FOURTH) begin
      four_d = four_q + 2'h1;
    end
    case (cfg_q.autocal)
      AC_NEVER: auto_req = 1'b0;
      AC_TO_TX: auto_req = idle_to_tx;
      AC_TO_IDLE: auto_req = tx_to_idle;
      AC_FOURTH: auto_req = tx_to_idle && four_q == FOURTH_LAST;
      default: auto_req = 1'b0;
    endcase
    // Requests while busy are dropped; one run already covers them
    cal_req = man_cal | auto_req;
    cal_d = cal_q;
    tmr_d = tmr_q;
    cp_done = 1'b0;
    case (cal_q)
      CAL_IDLE: begin
        if (cal_req && cfg_q.cp_en != 2'h0) begin
          cal_d = CAL_CP;
          tmr_d = CP_TMR_LOAD;
        end else if (cal_req) begin
          cal_d = CAL_VCO;
          tmr_d = VCO_TMR_LOAD;
        end
      end
      CAL_CP: begin
        if (tmr_q == 10'h000) begin
          cp_done = 1'b1;
          cal_d = CAL_VCO;
          tmr_d = VCO_TMR_LOAD;
        end else begin
          tmr_d = tmr_q - 10'h001;
        end
      end
      CAL_VCO: begin
        if (tmr_q == 10'h000) begin
          cal_d = CAL_IDLE;
        end else begin
          tmr_d = tmr_q - 10'h001;
        end
      end
      default: begin
        cal_d = CAL_IDLE;
        tmr_d = 10'h000;
      end
    endcase
    busy_d = cal_d != CAL_IDLE;
    cpst_d = cal_d == CAL_CP;
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      prev_q <= RS_IDLE;
      four_q <= 2'h0;
      cal_q <= CAL_IDLE;
      tmr_q <= 10'h000;
      busy_q <= 1'b0;
      cpst_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      four_q <= four_d;
      cal_q <= cal_d;
      tmr_q <= tmr_d;
      busy_q <= busy_d;
      cpst_q <= cpst_d;
    end
  end

  // ----------------------------------------
  // Power-on timeout
  // ----------------------------------------
  always_comb begin
    case (cfg_q.po)
      2'h0: po_target = PO_EXP0;
      2'h1: po_target = PO_EXP1;
      2'h2: po_target = PO_EXP2;
      default: po_target = PO_EXP3;
    endcase
    rip_d = rip_q;
    exp_d = exp_q;
    rdy_n_d = rdy_n_q;
    if (!I_XOSC_STABLE) begin
      rip_d = 6'h00;
      exp_d = 9'h000;
      rdy_n_d = 1'b1;
    end else if (rdy_n_q) begin
      rip_d = rip_q + 6'h01;
      if (rip_q == RIP_MAX) begin
        exp_d = exp_q + 9'h001;
        if (exp_q + 9'h001 >= po_target) begin
          rdy_n_d = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rip_q <= 6'h00;
      exp_q <= 9'h000;
      rdy_n_q <= 1'b1;
    end else begin
      rip_q <= rip_d;
      exp_q <= exp_d;
      rdy_n_q <= rdy_n_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign O_CHIP_READY_N = rdy_n_q;
  assign O_CAL_BUSY = busy_q;
  assign O_CAL_CP_STAGE = cpst_q;
  assign O_CP_CURRENT_CODE = cfg_q.cp_res;
  assign O_CP_CAL_CONFIG = cfg_q.cp_cfg;
  assign O_TX_LO_BUF_CURRENT = cfg_q.lobuf;
  assign O_PA_SETTING = pa_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);

  a_no_auto_cal: assert property (
    cal_q == CAL_IDLE && cfg_q.autocal == AC_NEVER && !man_cal |=> cal_q == CAL_IDLE && !busy_q)
    else $error("calibration started without strobe in manual mode");
  a_cal_on_tx: assert property (
    cal_q == CAL_IDLE && cfg_q.autocal == AC_TO_TX && idle_to_tx |=> busy_q)
    else $error("no calibration on idle to transmit");
  a_cal_on_idle: assert property (
    cal_q == CAL_IDLE && cfg_q.autocal == AC_TO_IDLE && tx_to_idle |=> busy_q)
    else $error("no calibration on transmit to idle");
  a_fourth_only: assert property (
    cal_q == CAL_IDLE && cfg_q.autocal == AC_FOURTH && tx_to_idle && !man_cal
    |=> busy_q == ($past(four_q) == FOURTH_LAST))
    else $error("fourth-return calibration count wrong");
  a_ready_needs_xosc: assert property (
    !I_XOSC_STABLE |=> rdy_n_q ##1 rdy_n_q)
    else $error("chip ready low without stable crystal");
  a_ready_count: assert property (
    $fell(rdy_n_q) |-> $past(rip_q) == RIP_MAX && exp_q == $past(po_target))
    else $error("chip ready after wrong number of expiries");
  a_po_kept_sleep: assert property (
    radio_sleep && !req.wr |=> cfg_q.po == $past(cfg_q.po) && cfg_q.autocal == AUTOCAL_RST)
    else $error("timeout select lost in sleep");
  a_cp_skip: assert property (
    cal_q == CAL_IDLE && cal_req && cfg_q.cp_en == 2'h0 |=> cal_q == CAL_VCO ##1 !cpst_q)
    else $error("charge pump stage ran while disabled");
  a_cp_result: assert property (
    cal_q == CAL_CP && tmr_q == 10'h000 |=> O_CP_CURRENT_CODE == $past(I_CP_CAL_CODE))
    else $error("charge pump result not stored");
  a_cp_override: assert property (
    req.wr && req.addr == A_CPCAL && !cp_done |=> O_CP_CURRENT_CODE == $past(req.wdata[3:0]))
    else $error("host override of result not applied");
  a_lobuf_write: assert property (
    req.wr && req.addr == A_FETX && !radio_sleep |=> O_TX_LO_BUF_CURRENT == $past(req.wdata[5:4]))
    else $error("lo buffer current not updated");
  a_reserved_zero: assert property (
    req.addr == A_RCCAL |-> rd_data[7:6] == 2'h0 && rd_data[1:0] == 2'h0)
    else $error("reserved bits read non-zero");

  c_cal_with_cp: cover property (cal_q == CAL_CP ##1 cal_q == CAL_VCO);
  c_fourth_cal: cover property (cfg_q.autocal == AC_FOURTH && tx_to_idle && four_q == FOURTH_LAST);
  c_ready_low: cover property ($fell(rdy_n_q));
  c_pa_top: cover property (ramp_idx == 3'h7);
endmodule

// File: rcpa_pkg.sv
// Package: offsets, fields, resets, timing and types of the cal/PA config block
package rcpa_pkg;
  // ----------------------------------------
  // Register offsets and strobes
  // ----------------------------------------
  localparam logic [5:0] A_RCCAL = 6'h18;
  localparam logic [5:0] A_FETX = 6'h22;
  localparam logic [5:0] A_CPCAL = 6'h23;
  localparam logic [5:0] A_STB_LO = 6'h30;
  localparam logic [5:0] A_MANCAL = 6'h33;
  localparam logic [5:0] A_PTAB = 6'h3E;
  localparam int HDR_RD = 7;
  localparam int HDR_BURST = 6;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int AUTOCAL_LSB = 4;
  localparam int PO_LSB = 2;
  localparam int LOBUF_LSB = 4;
  localparam int PAIDX_LSB = 0;
  localparam int CPCFG_LSB = 6;
  localparam int CPEN_LSB = 4;
  localparam int CPRES_LSB = 0;
  // ----------------------------------------
  // Field encodings and reset values
  // ----------------------------------------
  localparam logic [1:0] AC_NEVER = 2'h0;
  localparam logic [1:0] AC_TO_TX = 2'h1;
  localparam logic [1:0] AC_TO_IDLE = 2'h2;
  localparam logic [1:0] AC_FOURTH = 2'h3;
  localparam logic [1:0] FOURTH_LAST = 2'h3;
  localparam logic [1:0] AUTOCAL_RST = 2'h0;
  localparam logic [1:0] PO_RST = 2'h1;
  localparam logic [1:0] LOBUF_RST = 2'h1;
  localparam logic [2:0] PAIDX_RST = 3'h0;
  localparam logic [1:0] CPCFG_RST = 2'h2;
  localparam logic [1:0] CPEN_RST = 2'h2;
  localparam logic [3:0] CPRES_RST = 4'h9;
  localparam logic [7:0] PTAB_RST = 8'h00;
  localparam logic [5:0] RIP_MAX = 6'h3F;
  localparam logic [8:0] PO_EXP0 = 9'h001;
  localparam logic [8:0] PO_EXP1 = 9'h010;
  localparam logic [8:0] PO_EXP2 = 9'h040;
  localparam logic [8:0] PO_EXP3 = 9'h100;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS = 40;
  localparam int CP_STAGE_NS = 20000;
  localparam int VCO_STAGE_NS = 40000;
  localparam int RAMP_STEP_NS = 1000;
  localparam int CP_STAGE_CYC = (CP_STAGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int VCO_STAGE_CYC = (VCO_STAGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RAMP_STEP_CYC = (RAMP_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [9:0] CP_TMR_LOAD = 10'(CP_STAGE_CYC - 1);
  localparam logic [9:0] VCO_TMR_LOAD = 10'(VCO_STAGE_CYC - 1);
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    RS_SLEEP = 4'h1, RS_IDLE = 4'h2, RS_TX = 4'h4, RS_SYNTH_ON = 4'h8
  } rcpa_radio_t;
  typedef enum logic [2:0] {CAL_IDLE = 3'h1, CAL_CP = 3'h2, CAL_VCO = 3'h4} rcpa_cal_t;
  typedef struct packed {
    logic [1:0] autocal;
    logic [1:0] po;
    logic [1:0] lobuf;
    logic [2:0] pa_idx;
    logic [1:0] cp_cfg;
    logic [1:0] cp_en;
    logic [3:0] cp_res;
  } rcpa_cfg_t;
  typedef struct packed {
    logic [5:0] addr;
    logic wr;
    logic rd;
    logic cmd;
    logic [7:0] wdata;
  } rcpa_req_t;
  localparam rcpa_cfg_t CFG_RST = '{autocal: AUTOCAL_RST, po: PO_RST, lobuf: LOBUF_RST,
    pa_idx: PAIDX_RST, cp_cfg: CPCFG_RST, cp_en: CPEN_RST, cp_res: CPRES_RST};
endpackage

// File: rcpa_spi.sv
// Serial register port slave: header decode, burst addressing, read shifter
`timescale 1ns/1ps
module rcpa_spi import rcpa_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_si,
  input wire logic i_rdy_n,
  input wire logic [7:0] i_rd_data,
  output rcpa_req_t o_req,
  output logic o_so
);
  logic sclk_q, sclk_d, hdr_q, hdr_d, rd_q, rd_d;
  logic burst_q, burst_d, skip_q, skip_d, so_q, so_d;
  logic [2:0] bit_q, bit_d;
  logic [5:0] addr_q, addr_d;
  logic [7:0] sh_q, sh_d, out_q, out_d, byte_in;
  logic rise, fall;
  rcpa_req_t req_q, req_d;

  always_comb begin
    rise = i_sclk & ~sclk_q & ~i_cs_n;
    fall = ~i_sclk & sclk_q & ~i_cs_n;
    byte_in = {sh_q[6:0], i_si};
    sclk_d = i_sclk;
    {bit_d, sh_d, out_d, hdr_d, rd_d} = {bit_q, sh_q, out_q, hdr_q, rd_q};
    {burst_d, skip_d, so_d, addr_d} = {burst_q, skip_q, so_q, addr_q};
    req_d = req_q;
    req_d.wr = 1'b0;
    req_d.rd = 1'b0;
    req_d.cmd = 1'b0;
    if (i_cs_n) begin
      // Status bit first, ready flag only
      bit_d = 3'h0;
      hdr_d = 1'b0;
      skip_d = 1'b0;
      so_d = i_rdy_n;
      out_d = 8'h00;
    end else begin
      if (fall) begin
        so_d = out_q[7];
        out_d = {out_q[6:0], 1'b0};
      end
      if (req_q.rd) begin
        out_d = i_rd_data;
      end
      if (rise) begin
        sh_d = byte_in;
        bit_d = bit_q + 3'h1;
        if (bit_q == 3'h7 && !hdr_q) begin
          hdr_d = 1'b1;
          addr_d = byte_in[5:0];
          rd_d = byte_in[HDR_RD];
          burst_d = byte_in[HDR_BURST];
          req_d.addr = byte_in[5:0];
          if (byte_in[5:0] >= A_STB_LO && byte_in[5:0] < A_PTAB) begin
            req_d.cmd = 1'b1;
            skip_d = 1'b1;
          end else begin
            req_d.rd = byte_in[HDR_RD];
          end
        end else if (bit_q == 3'h7 && !skip_q) begin
          // Table pointer lives in the top, so its address never steps
          addr_d = (burst_q && addr_q != A_PTAB) ? addr_q + 6'h01 : addr_q;
          skip_d = ~burst_q;
          req_d.addr = rd_q ? addr_d : addr_q;
          req_d.wr = ~rd_q;
          req_d.rd = rd_q & burst_q;
          req_d.wdata = byte_in;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {sclk_q, hdr_q, rd_q, burst_q, skip_q} <= 5'h00;
      so_q <= 1'b1;
      bit_q <= 3'h0;
      addr_q <= 6'h00;
      sh_q <= 8'h00;
      out_q <= 8'h00;
      req_q <= '0;
    end else begin
      {sclk_q, hdr_q, rd_q, burst_q, skip_q} <= {sclk_d, hdr_d, rd_d, burst_d, skip_d};
      so_q <= so_d;
      bit_q <= bit_d;
      addr_q <= addr_d;
      sh_q <= sh_d;
      out_q <= out_d;
      req_q <= req_d;
    end
  end

  assign o_req = req_q;
  assign o_so = so_q;
endmodule

// File: rcpa_ramp.sv
// Power table index stepper for ramping and amplitude shaping
`timescale 1ns/1ps
module rcpa_ramp import rcpa_pkg::*; #(
  parameter int IDX_W = 3,
  parameter int STEP = RAMP_STEP_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tx_on,
  input wire logic i_ask,
  input wire logic i_bit,
  input wire logic [IDX_W-1:0] i_top,
  output logic [IDX_W-1:0] o_idx
);
  localparam int TW = $clog2(STEP + 1);
  logic [IDX_W-1:0] idx_q, idx_d, tgt;
  logic [TW-1:0] tmr_q, tmr_d;

  always_comb begin
    // Off or ASK zero heads for entry zero, else for the programmed index
    tgt = (!i_tx_on || (i_ask && !i_bit)) ? '0 : i_top;
    idx_d = idx_q;
    tmr_d = tmr_q;
    if (tgt == idx_q) begin
      tmr_d = '0;
    end else if (tmr_q == TW'(STEP - 1)) begin
      tmr_d = '0;
      idx_d = (tgt > idx_q) ? idx_q + 1'b1 : idx_q - 1'b1;
    end else begin
      tmr_d = tmr_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idx_q <= '0;
      tmr_q <= '0;
    end else begin
      idx_q <= idx_d;
      tmr_q <= tmr_d;
    end
  end

  assign o_idx = idx_q;

  a_ramp_one_step: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    idx_q != $past(idx_q) |-> (idx_q == $past(idx_q) + 1'b1 || idx_q == $past(idx_q) - 1'b1))
    else $error("ramp index jumped by more than one entry");
  a_ask_zero_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_tx_on && i_ask && !i_bit && idx_q == '0 |=> idx_q == '0)
    else $error("ask zero symbol left table entry zero");
  a_off_stays_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_tx_on && idx_q == '0 |=> idx_q == '0)
    else $error("power index rose while not transmitting");
endmodule

// File: rcpa_host.sv
// Host model: serial register port master, mode 0
`timescale 1ns/1ps
module rcpa_host (
  input wire logic i_clk,
  input wire logic i_so,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_si
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_si = 1'b0;
  end
  // ----------------------------------------
  // Frame: header then n data bytes
  // ----------------------------------------
  // Half period 5 clocks, margin over the 4-clock minimum
  task automatic xfer(input logic [7:0] h, input int n, input logic [7:0] wd[8], output logic [7:0] rd);
    logic [7:0] b;
    @(posedge i_clk) o_cs_n <= 1'b0;
    for (int k = 0; k <= n; k++) begin
      b = (k == 0) ? h : wd[k-1];
      for (int i = 7; i >= 0; i--) begin
        o_si <= b[i];
        repeat (5) @(posedge i_clk);
        o_sclk <= 1'b1;
        rd[i] = i_so;
        repeat (5) @(posedge i_clk);
        o_sclk <= 1'b0;
      end
    end
    repeat (5) @(posedge i_clk);
    o_cs_n <= 1'b1;
    // Released line must not keep the last bit
    o_si <= ~o_si;
    repeat (5) @(posedge i_clk);
  endtask
endmodule

// File: radio_cal_and_pa_config_tb.sv
// Testbench: register port, calibration triggers, power-on timeout, PA table
`timescale 1ns/1ps
module radio_cal_and_pa_config_tb import rcpa_pkg::*; ;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic xosc = 1'b0;
  logic ask = 1'b0;
  logic tbit = 1'b0;
  logic rec = 1'b0;
  rcpa_radio_t st = RS_IDLE;
  logic [3:0] cpc = 4'h0;
  logic cs_n, sclk, si, so, rdy_n, busy, cps;
  logic [3:0] cpcode;
  logic [1:0] cpcfg, lobuf;
  logic [7:0] pa, rd, d;
  logic [7:0] tab[8];
  logic [7:0] wd[8];
  logic [7:0] seq[$];
  int failures = 0;
  int samples_checked = 0;
  int cyc = 0;
  int cals = 0;
  always #20 clk = ~clk;
  always @(posedge busy) cals++;
  always @(posedge clk) if (rec && (seq.size() == 0 || pa !== seq[$])) seq.push_back(pa);
  always @(posedge clk) begin
    cyc++;
    if (cyc == 99000) begin
      failures++;
      final_report();
    end
  end
  rcpa_top DUT (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_SPI_CS_N(cs_n), .I_SPI_SCLK(sclk), .I_SPI_SI(si),
    .I_RADIO_STATE(st), .I_XOSC_STABLE(xosc), .I_ASK_MODE(ask), .I_TX_BIT(tbit), .I_CP_CAL_CODE(cpc),
    .O_SPI_SO(so), .O_CHIP_READY_N(rdy_n), .O_CAL_BUSY(busy), .O_CAL_CP_STAGE(cps),
    .O_CP_CURRENT_CODE(cpcode), .O_CP_CAL_CONFIG(cpcfg), .O_TX_LO_BUF_CURRENT(lobuf), .O_PA_SETTING(pa));
  rcpa_host HOST (.i_clk(clk), .i_so(so), .o_cs_n(cs_n), .o_sclk(sclk), .o_si(si));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic int po_exp(int p);
    return 64 * (p == 0 ? 1 : 1 << (2 * p + 2));
  endfunction
  // First of five trips goes via synth-on, so it is no return from transmit
  function automatic int ncal(int m);
    return m == 1 ? 5 : m == 2 ? 4 : m == 3 ? 1 : 0;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    wd[0] = v;
    HOST.xfer(a, 1, wd, rd);
  endtask
  task automatic rdr(input logic [7:0] a, input logic [7:0] e);
    HOST.xfer(a | 8'h80, 1, wd, rd);
    chk(rd, e);
  endtask
  task automatic pause(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    void'($urandom(36175));
    pause(6);
    rst_n <= 1'b1;
    pause(1);
    chk({cpcfg, 2'h0, cpcode}, 8'h89);
    chk({2'h0, lobuf, 4'h0}, 8'h10);
    rdr(8'h18, 8'h04);
    rdr(8'h22, 8'h10);
    rdr(8'h23, 8'hA9);
    rdr(8'h05, 8'h00);
    d = 8'($urandom);
    wr(8'h22, d);
    chk({2'h0, lobuf, 4'h0}, d & 8'h30);
    rdr(8'h22, d & 8'h37);
    wr(8'h18, 8'hFF);
    rdr(8'h18, 8'h3C);
    wr(8'h18, 8'h18);
    st <= RS_SLEEP;
    pause(4);
    st <= RS_IDLE;
    rdr(8'h18, 8'h08);
    $display("test registers done");
    for (int p = 0; p < 4; p++) begin
      wr(8'h18, 8'(p << 2));
      xosc <= 1'b0;
      pause(3);
      xosc <= 1'b1;
      pause(po_exp(p) - 4);
      chk({7'h0, rdy_n}, 8'h01);
      pause(8);
      chk({7'h0, rdy_n}, 8'h00);
    end
    $display("test power-on done");
    cpc <= 4'($urandom) | 4'h1;
    wr(8'h23, 8'hA0);
    HOST.xfer(8'h33, 0, wd, rd);
    pause(100);
    chk({7'h0, cps}, 8'h01);
    pause(1500);
    chk({4'h0, cpcode}, {4'h0, cpc});
    d = 8'($urandom) & 8'h0F;
    wr(8'h23, 8'h80 | d);
    chk({4'h0, cpcode}, d);
    cpc <= ~d[3:0];
    HOST.xfer(8'h33, 0, wd, rd);
    pause(100);
    chk({7'h0, cps}, 8'h00);
    pause(1000);
    chk({4'h0, cpcode}, d);
    for (int m = 0; m < 4; m++) begin
      wr(8'h18, 8'(m << 4) | 8'h08);
      cals = 0;
      for (int k = 0; k < 5; k++) begin
        st <= (k == 0) ? RS_SYNTH_ON : RS_TX;
        pause(1100);
        st <= RS_IDLE;
        pause(1100);
      end
      chk(8'(cals), 8'(ncal(m)));
    end
    $display("test calibration done");
    for (int i = 0; i < 8; i++) wd[i] = 8'(i << 5) | (8'($urandom) & 8'h1F);
    tab = wd;
    HOST.xfer(8'h7E, 8, wd, rd);
    HOST.xfer(8'hFE, 8, wd, rd);
    chk(rd, tab[7]);
    wr(8'h22, 8'h15);
    rec <= 1'b1;
    st <= RS_TX;
    pause(200);
    st <= RS_IDLE;
    pause(200);
    chk(8'(seq.size()), 8'h0B);
    for (int i = 0; i < 6; i++) chk(seq[i], tab[i]);
    for (int i = 6; i < 11; i++) chk(seq[i], tab[10-i]);
    ask <= 1'b1;
    st <= RS_TX;
    pause(200);
    chk(pa, tab[0]);
    tbit <= 1'b1;
    pause(200);
    chk(pa, tab[5]);
    $display("test power table done");
    final_report();
  end
endmodule
